// [logic/shcc_pkg.sv]
`default_nettype none
package shcc_pkg;

    // ----------------------------------------------------------------
    // Register map (byte addresses on the register bus)
    // ----------------------------------------------------------------
    localparam logic [31:0] SHCC_CH0_ADDR = 32'h4ac0_0080;
    localparam logic [31:0] SHCC_CH1_ADDR = 32'h4a80_0080;
    localparam logic [31:0] SHCC_IRQ_STS_ADDR = 32'h4ac0_00a0;
    localparam logic [31:0] SHCC_IRQ_MASK_ADDR = 32'h4ac0_00a4;

    // Writable bits of the control word; levels and low nibble are read only
    localparam logic [31:0] SHCC_CFG_WR_MASK = 32'hff00_fff0;
    localparam logic [31:0] SHCC_CFG_RESET = 32'h0000_0000;
    localparam logic [3:0] SHCC_IRQ_RESET = 4'h0;

    // Interrupt layout: two bits per channel
    localparam int SHCC_NCH = 2;
    localparam int SHCC_IRQ_W = 4;
    localparam int SHCC_IRQ_INS = 0;
    localparam int SHCC_IRQ_REM = 1;

    // Filter clock exponent offset and debounce lengths in card clock periods
    localparam logic [4:0] SHCC_FLT_BASE = 5'h05;
    localparam logic [6:0] SHCC_DEB_LEN1 = 7'h04;
    localparam logic [6:0] SHCC_DEB_LEN2 = 7'h10;
    localparam logic [6:0] SHCC_DEB_LEN3 = 7'h40;

    // Bus answers
    localparam logic [1:0] SHCC_RESP_OKAY = 2'h0;
    localparam logic [1:0] SHCC_RESP_DECERR = 2'h3;

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef struct packed {
        logic async_clear_en;
        logic conflict_mask;
        logic detect_line_invert;
        logic removal_condition_select;
        logic [3:0] filter_clock_divider_select;
        logic [7:0] data_line_levels;
        logic tx_feedback_clock_enable;
        logic rx_feedback_clock_enable;
        logic detect_source_select;
        logic output_power_sync_enable;
        logic tx_start_busy_check;
        logic [1:0] debounce_length;
        logic card_clock_hold_enable;
        logic read_wait_release_mode;
        logic buffer_port_read_disable;
        logic [1:0] base_clock_source;
        logic [3:0] reserved;
    } shcc_cfg_t;

    typedef enum logic [1:0] {
        SHCC_NO_CARD,
        SHCC_DEBOUNCE,
        SHCC_INSERTED
    } shcc_det_t;

    typedef enum logic [1:0] {
        SHCC_CLK_BUS,
        SHCC_CLK_DEDICATED,
        SHCC_CLK_EXTERNAL
    } shcc_clk_t;

endpackage
`default_nettype wire

// [logic/shcc_top.sv]
// The AXI4-Lite interface to the registers is this design's own decision.
`timescale 1ns/100ps
`default_nettype none
module shcc_top (
    // Clock, reset, enable
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic i_ce,
    // AXI4-Lite write channels
    input wire logic i_awvalid,
    input wire logic [31:0] i_awaddr,
    output logic o_awready,
    input wire logic i_wvalid,
    input wire logic [31:0] i_wdata,
    input wire logic [3:0] i_wstrb,
    output logic o_wready,
    output logic o_bvalid,
    output logic [1:0] o_bresp,
    input wire logic i_bready,
    // AXI4-Lite read channels
    input wire logic i_arvalid,
    input wire logic [31:0] i_araddr,
    output logic o_arready,
    output logic o_rvalid,
    output logic [31:0] o_rdata,
    output logic [1:0] o_rresp,
    input wire logic i_rready,
    // Card side pins, asynchronous
    input wire logic i_card_clk,
    input wire logic [1:0] i_card_detect_pin_n,
    input wire logic [1:0][7:0] i_data_line,
    // Core side, same clock
    input wire logic [1:0][1:0] i_err_conflict,
    input wire logic [1:0] i_cmd_oe,
    input wire logic [1:0][7:0] i_dat_oe,
    input wire logic [1:0] i_bus_power,
    input wire logic [1:0] i_tx_start_req,
    input wire logic [1:0] i_card_busy,
    // Outputs to the core
    output wire logic [1:0][1:0] o_err_conflict,
    output wire logic [1:0] o_cmd_oe,
    output wire logic [1:0][7:0] o_dat_oe,
    output wire logic [1:0] o_tx_start,
    output wire logic [1:0] o_card_inserted,
    output wire shcc_pkg::shcc_cfg_t [1:0] o_cfg,
    output wire shcc_pkg::shcc_clk_t [1:0] o_base_clk,
    output logic o_irq
);

    // ----------------------------------------------------------------
    // Reset and card clock sampling
    // ----------------------------------------------------------------

    logic rst_s1_q;
    logic rst_n_q;
    logic clk_s1_q;
    logic clk_s2_q;
    logic clk_s3_q;
    logic card_rise;

    // Reset release through two flops; assertion stays asynchronous
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            rst_s1_q <= 1'b0;
            rst_n_q <= 1'b0;
        end else if (i_ce) begin
            rst_s1_q <= 1'b1;
            rst_n_q <= rst_s1_q;
        end
    end

    // Card clock is only a sampled level; 160 ns against 4 ns gives ample margin
    always_ff @(posedge i_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            clk_s1_q <= 1'b0;
            clk_s2_q <= 1'b0;
            clk_s3_q <= 1'b0;
        end else if (i_ce) begin
            clk_s1_q <= i_card_clk;
            clk_s2_q <= clk_s1_q;
            clk_s3_q <= clk_s2_q;
        end
    end

    assign card_rise = clk_s2_q & ~clk_s3_q;

    // ----------------------------------------------------------------
    // AXI4-Lite slave
    // ----------------------------------------------------------------

    logic aw_have_q;
    logic w_have_q;
    logic [31:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic awready_q;
    logic wready_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic arready_q;
    logic rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0] rresp_q;
    localparam int SHCC_NCH_L = shcc_pkg::SHCC_NCH;
    logic do_write;
    logic [SHCC_NCH_L-1:0] wr_ch;
    logic wr_sts;
    logic wr_mask;
    logic [31:0] wbits;
    logic [31:0] rd_d;
    logic rd_hit;
    logic [3:0] mask_q;
    logic [3:0] sts_all;
    shcc_pkg::shcc_cfg_t cfg_q [2];
    shcc_pkg::shcc_cfg_t rd_view [2];

    // Bit enables from byte strobes, so partial writes leave other lanes alone
    assign wbits = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
    assign do_write = aw_have_q & w_have_q & ~bvalid_q;
    assign wr_ch[0] = do_write & (awaddr_q == shcc_pkg::SHCC_CH0_ADDR);
    assign wr_ch[1] = do_write & (awaddr_q == shcc_pkg::SHCC_CH1_ADDR);
    assign wr_sts = do_write & (awaddr_q == shcc_pkg::SHCC_IRQ_STS_ADDR);
    assign wr_mask = do_write & (awaddr_q == shcc_pkg::SHCC_IRQ_MASK_ADDR);

    // Address and data are taken in either order; one write in flight
    always_ff @(posedge i_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            awaddr_q <= 32'h0000_0000;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
            awready_q <= 1'b1;
            wready_q <= 1'b1;
            bvalid_q <= 1'b0;
            bresp_q <= shcc_pkg::SHCC_RESP_OKAY;
        end else if (i_ce) begin
            if (awready_q && i_awvalid) begin
                aw_have_q <= 1'b1;
                awaddr_q <= i_awaddr;
                awready_q <= 1'b0;
            end
            if (wready_q && i_wvalid) begin
                w_have_q <= 1'b1;
                wdata_q <= i_wdata;
                wstrb_q <= i_wstrb;
                wready_q <= 1'b0;
            end
            if (do_write) begin
                aw_have_q <= 1'b0;
                w_have_q <= 1'b0;
                bvalid_q <= 1'b1;
                bresp_q <= (|wr_ch || wr_sts || wr_mask) ? shcc_pkg::SHCC_RESP_OKAY
                                                        : shcc_pkg::SHCC_RESP_DECERR;
            end
            if (bvalid_q && i_bready) begin
                bvalid_q <= 1'b0;
                awready_q <= 1'b1;
                wready_q <= 1'b1;
            end
        end
    end

    // Read data selection; unmapped reads return zero with a decode error
    always_comb begin
        rd_d = 32'h0000_0000;
        rd_hit = 1'b1;
        unique case (i_araddr)
            shcc_pkg::SHCC_CH0_ADDR: rd_d = rd_view[0];
            shcc_pkg::SHCC_CH1_ADDR: rd_d = rd_view[1];
            shcc_pkg::SHCC_IRQ_STS_ADDR: rd_d = {28'h000_0000, sts_all};
            shcc_pkg::SHCC_IRQ_MASK_ADDR: rd_d = {28'h000_0000, mask_q};
            default: rd_hit = 1'b0;
        endcase
    end

    // Read channel: data is sampled when the address is taken
    always_ff @(posedge i_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            arready_q <= 1'b1;
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            rresp_q <= shcc_pkg::SHCC_RESP_OKAY;
        end else if (i_ce) begin
            if (arready_q && i_arvalid) begin
                arready_q <= 1'b0;
                rvalid_q <= 1'b1;
                rdata_q <= rd_d;
                rresp_q <= rd_hit ? shcc_pkg::SHCC_RESP_OKAY : shcc_pkg::SHCC_RESP_DECERR;
            end
            if (rvalid_q && i_rready) begin
                rvalid_q <= 1'b0;
                arready_q <= 1'b1;
            end
        end
    end

    assign o_awready = awready_q;
    assign o_wready = wready_q;
    assign o_bvalid = bvalid_q;
    assign o_bresp = bresp_q;
    assign o_arready = arready_q;
    assign o_rvalid = rvalid_q;
    assign o_rdata = rdata_q;
    assign o_rresp = rresp_q;

    // ----------------------------------------------------------------
    // Interrupt mask and output
    // ----------------------------------------------------------------

    // Mask register, same layout as the status register
    always_ff @(posedge i_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            mask_q <= shcc_pkg::SHCC_IRQ_RESET;
        end else if (i_ce && wr_mask && wstrb_q[0]) begin
            mask_q <= wdata_q[3:0];
        end
    end

    // Level output lags the status bits by one cycle
    always_ff @(posedge i_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            o_irq <= 1'b0;
        end else if (i_ce) begin
            o_irq <= |(sts_all & mask_q);
        end
    end

    // ----------------------------------------------------------------
    // Per channel logic
    // ----------------------------------------------------------------

    for (genvar g = 0; g < SHCC_NCH_L; g++) begin : g_ch
        logic pin_s1_q;
        logic pin_s2_q;
        logic [7:0] dat_s1_q;
        logic [7:0] dat_s2_q;
        logic det_raw;
        logic [19:0] flt_cnt_q;
        logic [19:0] flt_lim;
        logic flt_tick;
        logic flt_lvl_q;
        logic deb_lvl_q;
        logic [6:0] deb_cnt_q;
        logic [6:0] deb_len;
        logic settle;
        logic ins_ev;
        logic rem_ev;
        logic [1:0] sts_q;
        logic [1:0] sts_clr;
        logic [1:0] err_q;
        logic cmd_oe_q;
        logic [7:0] dat_oe_q;
        logic tx_start_q;
        logic ins_q;
        shcc_pkg::shcc_det_t det_q;
        shcc_pkg::shcc_det_t det_d;
        shcc_pkg::shcc_clk_t base_q;

        // Pins cross into the bus clock through two flops
        always_ff @(posedge i_clk or negedge rst_n_q) begin
            if (!rst_n_q) begin
                pin_s1_q <= 1'b1;
                pin_s2_q <= 1'b1;
                dat_s1_q <= 8'h00;
                dat_s2_q <= 8'h00;
            end else if (i_ce) begin
                pin_s1_q <= i_card_detect_pin_n[g];
                pin_s2_q <= pin_s1_q;
                dat_s1_q <= i_data_line[g];
                dat_s2_q <= dat_s1_q;
            end
        end

        always_ff @(posedge i_clk or negedge rst_n_q) begin
            if (!rst_n_q) begin
                cfg_q[g] <= shcc_pkg::SHCC_CFG_RESET;
            end else if (i_ce && wr_ch[g]) begin
                cfg_q[g] <= (cfg_q[g] & ~(wbits & shcc_pkg::SHCC_CFG_WR_MASK))
                            | (wdata_q & wbits & shcc_pkg::SHCC_CFG_WR_MASK);
            end
        end

        always_comb begin
            rd_view[g] = cfg_q[g];
            rd_view[g].data_line_levels = dat_s2_q;
        end

        // pin or data line 3; optional inversion of data line 3
        assign det_raw = cfg_q[g].detect_source_select ? (dat_s2_q[3] ^ cfg_q[g].detect_line_invert)
                                                       : ~pin_s2_q;

        // divider limit; exponent 20 wraps to all ones, which is still right
        assign flt_lim = (20'h0_0001 << (5'(cfg_q[g].filter_clock_divider_select) + shcc_pkg::SHCC_FLT_BASE))
                         - 20'h0_0001;
        assign flt_tick = card_rise && (flt_cnt_q == flt_lim);

        // filter clock samples the detect level
        always_ff @(posedge i_clk or negedge rst_n_q) begin
            if (!rst_n_q) begin
                flt_cnt_q <= 20'h0_0000;
                flt_lvl_q <= 1'b0;
            end else if (i_ce && card_rise) begin
                flt_cnt_q <= flt_tick ? 20'h0_0000 : flt_cnt_q + 20'h0_0001;
                if (flt_tick) begin
                    flt_lvl_q <= det_raw;
                end
            end
        end

        always_comb begin
            unique case (cfg_q[g].debounce_length)
                2'h0: deb_len = 7'h00;
                2'h1: deb_len = shcc_pkg::SHCC_DEB_LEN1;
                2'h2: deb_len = shcc_pkg::SHCC_DEB_LEN2;
                2'h3: deb_len = shcc_pkg::SHCC_DEB_LEN3;
            endcase
        end

        // settle after the level has held for the set length
        assign settle = (flt_lvl_q == deb_lvl_q) && (deb_cnt_q >= deb_len);

        // Detect state machine and its events
        always_comb begin
            det_d = det_q;
            ins_ev = 1'b0;
            rem_ev = 1'b0;
            unique case (det_q)
                shcc_pkg::SHCC_NO_CARD: begin
                    if (flt_lvl_q) begin
                        det_d = shcc_pkg::SHCC_DEBOUNCE;
                    end
                end
                shcc_pkg::SHCC_DEBOUNCE: begin
                    if (settle) begin
                        det_d = deb_lvl_q ? shcc_pkg::SHCC_INSERTED : shcc_pkg::SHCC_NO_CARD;
                        ins_ev = deb_lvl_q;
                        // removal reported on entering no card when removal_condition_select is set
                        rem_ev = ~deb_lvl_q & cfg_q[g].removal_condition_select;
                    end
                end
                shcc_pkg::SHCC_INSERTED: begin
                    if (!flt_lvl_q) begin
                        det_d = shcc_pkg::SHCC_DEBOUNCE;
                        rem_ev = ~cfg_q[g].removal_condition_select;
                    end
                end
                default: det_d = shcc_pkg::SHCC_NO_CARD;
            endcase
        end

        // debounce counter restarts on any level change
        always_ff @(posedge i_clk or negedge rst_n_q) begin
            if (!rst_n_q) begin
                det_q <= shcc_pkg::SHCC_NO_CARD;
                deb_lvl_q <= 1'b0;
                deb_cnt_q <= 7'h00;
                ins_q <= 1'b0;
            end else if (i_ce) begin
                det_q <= det_d;
                ins_q <= (det_d == shcc_pkg::SHCC_INSERTED);
                if (det_q != shcc_pkg::SHCC_DEBOUNCE || flt_lvl_q != deb_lvl_q) begin
                    deb_lvl_q <= flt_lvl_q;
                    deb_cnt_q <= 7'h00;
                end else if (card_rise && deb_cnt_q < deb_len) begin
                    deb_cnt_q <= deb_cnt_q + 7'h01;
                end
            end
        end

        // Sticky status, write one to clear; a new event wins over the clear
        assign sts_clr = (wr_sts && wstrb_q[0]) ? wdata_q[2*g +: 2] : 2'h0;
        always_ff @(posedge i_clk or negedge rst_n_q) begin
            if (!rst_n_q) begin
                sts_q <= 2'h0;
            end else if (i_ce) begin
                sts_q <= (sts_q & ~sts_clr) | {rem_ev, ins_ev};
            end
        end
        assign sts_all[2*g +: 2] = sts_q;

        // Core side gating, registered so every output leaves a flop
        always_ff @(posedge i_clk or negedge rst_n_q) begin
            if (!rst_n_q) begin
                err_q <= 2'h0;
                cmd_oe_q <= 1'b0;
                dat_oe_q <= 8'h00;
                tx_start_q <= 1'b0;
            end else if (i_ce) begin
                err_q <= cfg_q[g].conflict_mask ? 2'h0 : i_err_conflict[g];
                cmd_oe_q <= i_cmd_oe[g] & (~cfg_q[g].output_power_sync_enable | i_bus_power[g]);
                dat_oe_q <= i_dat_oe[g] & {8{~cfg_q[g].output_power_sync_enable | i_bus_power[g]}};
                tx_start_q <= i_tx_start_req[g] & ~(cfg_q[g].tx_start_busy_check & i_card_busy[g]);
            end
        end

        always_ff @(posedge i_clk or negedge rst_n_q) begin
            if (!rst_n_q) begin
                base_q <= shcc_pkg::SHCC_CLK_BUS;
            end else if (i_ce) begin
                unique case (cfg_q[g].base_clock_source)
                    2'h2: base_q <= shcc_pkg::SHCC_CLK_DEDICATED;
                    2'h3: base_q <= shcc_pkg::SHCC_CLK_EXTERNAL;
                    default: base_q <= shcc_pkg::SHCC_CLK_BUS;
                endcase
            end
        end

        // async clear; feedback clocks; clock hold
        // Read Wait mode; buffer port read block; the core acts on these
        assign o_cfg[g] = cfg_q[g];
        assign o_err_conflict[g] = err_q;
        assign o_cmd_oe[g] = cmd_oe_q;
        assign o_dat_oe[g] = dat_oe_q;
        assign o_tx_start[g] = tx_start_q;
        assign o_card_inserted[g] = ins_q;
        assign o_base_clk[g] = base_q;
    end

endmodule
`default_nettype wire

// [tb/shcc_top_asserts.sv]
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// Port checker
// ----------------------------------------
module shcc_top_asserts (
    // Clock, reset, enable
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic i_ce,
    // Register bus
    input wire logic i_awvalid,
    input wire logic o_awready,
    input wire logic i_wvalid,
    input wire logic o_wready,
    input wire logic o_bvalid,
    input wire logic [1:0] o_bresp,
    input wire logic i_bready,
    input wire logic i_arvalid,
    input wire logic o_arready,
    input wire logic o_rvalid,
    input wire logic [31:0] o_rdata,
    input wire logic i_rready,
    // Core side
    input wire logic [1:0][1:0] i_err_conflict,
    input wire logic [1:0] i_cmd_oe,
    input wire logic [1:0] i_bus_power,
    input wire logic [1:0] i_tx_start_req,
    input wire logic [1:0] i_card_busy,
    input wire logic [1:0][1:0] o_err_conflict,
    input wire logic [1:0] o_cmd_oe,
    input wire logic [1:0] o_tx_start,
    input wire shcc_pkg::shcc_cfg_t [1:0] o_cfg,
    input wire shcc_pkg::shcc_clk_t [1:0] o_base_clk
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rstn);
    // Take steps of a write and a read
    sequence s_wr_take;
        i_awvalid && o_awready && i_wvalid && o_wready;
    endsequence
    sequence s_ar_take;
        i_arvalid && o_arready;
    endsequence
    // Write answer comes two edges after a joint take, read answer one edge after its take; ready stays low meanwhile
    a_write_answer: assert property (s_wr_take |=> !o_awready ##1 o_bvalid)
        else $error("write answer late");
    a_read_answer: assert property (s_ar_take |=> o_rvalid && !o_arready)
        else $error("read answer late");
    // A response held back by the master must not change
    a_bresp_hold: assert property (o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp))
        else $error("write response dropped");
    a_rdata_hold: assert property (o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata))
        else $error("read data dropped");
    a_conflict_mask: assert property (
        i_ce |=> o_err_conflict[0] == ($past(o_cfg[0].conflict_mask) ? 2'h0 : $past(i_err_conflict[0])))
        else $error("conflict bits not masked");
    a_power_gate: assert property (
        i_ce |=> o_cmd_oe[0] == ($past(i_cmd_oe[0]) & ($past(i_bus_power[0])
        | !$past(o_cfg[0].output_power_sync_enable)))) else $error("command enable gating wrong");
    a_busy_check: assert property (
        i_ce |=> o_tx_start[0] == ($past(i_tx_start_req[0])
        & !($past(o_cfg[0].tx_start_busy_check) & $past(i_card_busy[0])))) else $error("tx start while busy");
    // Checked once the field has settled, so a one-cycle lag is allowed
    a_base_select: assert property (
        $stable(o_cfg[0].base_clock_source) |-> 2'(o_base_clk[0]) == (o_cfg[0].base_clock_source[1]
        ? o_cfg[0].base_clock_source - 2'h1 : 2'h0)) else $error("base clock select wrong");
    a_fixed_fields: assert property (
        o_cfg[0].data_line_levels == 8'h00 && o_cfg[1].reserved == 4'h0) else $error("read-only field stored");
endmodule
`default_nettype wire

// [tb/shcc_card_model.sv]
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// Card slot model
// ----------------------------------------
module shcc_card_model (
    // Bench control
    input wire logic [1:0] i_present,
    input wire logic [1:0][7:0] i_levels,
    // Card pins
    output var logic o_card_clk,
    output logic [1:0] o_detect_pin_n,
    output logic [1:0][7:0] o_data_line
);
    // Card clock runs free with an odd offset so no edge lines up with the bus clock
    initial begin
        o_card_clk = 1'b0;
        #13;
        forever #80 o_card_clk = ~o_card_clk;
    end
    // Detect pin pulled low only by a seated card
    assign o_detect_pin_n = ~i_present;
    assign o_data_line = i_levels;
endmodule
`default_nettype wire

// [tb/shcc_top_tb_top.sv]
`timescale 1ns/100ps
`default_nettype none
module shcc_top_tb_top;
    // ----------------------------------------
    // Bench signals, named after the ports
    // ----------------------------------------
    logic i_clk = 1'b0, i_rstn = 1'b0, i_ce = 1'b1;
    logic i_awvalid = 1'b0, i_wvalid = 1'b0, i_bready = 1'b0, i_arvalid = 1'b0, i_rready = 1'b0;
    logic [31:0] i_awaddr = 32'h0, i_wdata = 32'h0, i_araddr = 32'h0, o_rdata, rdat;
    logic [3:0] i_wstrb = 4'hf;
    wire logic i_card_clk;
    wire logic [1:0] i_card_detect_pin_n;
    wire logic [1:0][7:0] i_data_line;
    logic [1:0][1:0] i_err_conflict = 4'h0, o_err_conflict;
    logic [1:0] i_cmd_oe = 2'h0, i_bus_power = 2'h0, i_tx_start_req = 2'h0, i_card_busy = 2'h0, present = 2'h0;
    logic [1:0][7:0] i_dat_oe = 16'h0, levels = 16'h3c5a, o_dat_oe;
    logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_irq;
    logic [1:0] o_bresp, o_rresp, o_cmd_oe, o_tx_start, o_card_inserted, rsp;
    shcc_pkg::shcc_cfg_t [1:0] o_cfg;
    shcc_pkg::shcc_clk_t [1:0] o_base_clk;
    int error_cnt = 0, n_compared = 0;
    logic [31:0] adr [4] = '{shcc_pkg::SHCC_CH0_ADDR, shcc_pkg::SHCC_CH1_ADDR,
        shcc_pkg::SHCC_IRQ_STS_ADDR, shcc_pkg::SHCC_IRQ_MASK_ADDR};
    logic [31:0] rst [4] = '{32'h005a_0000, 32'h003c_0000, 32'h0, 32'h0};

    shcc_top dut (.*);
    shcc_card_model u_card (.i_present(present), .i_levels(levels), .o_card_clk(i_card_clk),
        .o_detect_pin_n(i_card_detect_pin_n), .o_data_line(i_data_line));

    always #2 i_clk = ~i_clk;

    task automatic chk(input string nm, input logic [31:0] seen, exp);
        n_compared++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // Address and data offered together; bready raised once the answer shows
    task automatic wr(input logic [31:0] a, d);
        @(posedge i_clk);
        i_awvalid <= 1'b1;
        i_awaddr <= a;
        i_wvalid <= 1'b1;
        i_wdata <= d;
        do begin
            @(posedge i_clk);
            if (o_awready === 1'b1) i_awvalid <= 1'b0;
            if (o_wready === 1'b1) i_wvalid <= 1'b0;
        end while (o_bvalid !== 1'b1);
        i_bready <= 1'b1;
        @(posedge i_clk);
        rsp = o_bresp;
        i_bready <= 1'b0;
    endtask
    task automatic rd(input logic [31:0] a);
        @(posedge i_clk);
        i_arvalid <= 1'b1;
        i_araddr <= a;
        do begin
            @(posedge i_clk);
            if (o_arready === 1'b1) i_arvalid <= 1'b0;
        end while (o_rvalid !== 1'b1);
        i_rready <= 1'b1;
        @(posedge i_clk);
        rdat = o_rdata;
        rsp = o_rresp;
        i_rready <= 1'b0;
    endtask
    task automatic complete_run();
        $display("Mismatches %0d of %0d compared", error_cnt, n_compared);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    initial begin
        repeat (12) @(posedge i_clk);
        i_rstn <= 1'b1;
        repeat (4) @(posedge i_clk);
        for (int i = 0; i < 4; i++) begin
            rd(adr[i]);
            chk("reset", rdat, rst[i]);
        end
        // Level bits and low nibble ignore writes; the other channel is untouched
        wr(adr[0], 32'hffff_ffff);
        rd(adr[0]);
        chk("ctl0", rdat, 32'hff5a_fff0);
        rd(adr[1]);
        chk("ctl1", rdat, 32'h003c_0000);
        wr(32'h4ac0_0090, 32'hffff_ffff);
        chk("bresp", {30'h0, rsp}, 32'h3);
        rd(32'h4ac0_0090);
        chk("rresp", {30'h0, rsp}, 32'h3);
        chk("rdata", rdat, 32'h0);
        // Core gating, channel 0 only, bus power off
        i_err_conflict <= 4'hf;
        i_cmd_oe <= 2'h3;
        i_dat_oe <= 16'hffff;
        i_tx_start_req <= 2'h3;
        i_card_busy <= 2'h3;
        for (int m = 0; m < 2; m++) begin
            wr(adr[0], m ? 32'h4000_1800 : 32'h0);
            repeat (2) @(posedge i_clk);
            chk("conflict", {28'h0, o_err_conflict}, m ? 32'hc : 32'hf);
            chk("cmd_oe", {30'h0, o_cmd_oe}, m ? 32'h2 : 32'h3);
            chk("dat_oe", {16'h0, o_dat_oe}, m ? 32'hff00 : 32'hffff);
            chk("tx_start", {30'h0, o_tx_start}, m ? 32'h2 : 32'h3);
        end
        i_bus_power <= 2'h3;
        i_card_busy <= 2'h0;
        repeat (3) @(posedge i_clk);
        chk("cmd_oe", {30'h0, o_cmd_oe}, 32'h3);
        chk("tx_start", {30'h0, o_tx_start}, 32'h3);
        // Enable low must hold the gated enables although bus power drops
        i_ce <= 1'b0;
        i_bus_power <= 2'h0;
        repeat (3) @(posedge i_clk);
        chk("freeze", {30'h0, o_cmd_oe}, 32'h3);
        i_ce <= 1'b1;
        i_bus_power <= 2'h3;
        for (int s = 0; s < 4; s++) begin
            wr(adr[0], 32'(s) << 4);
            repeat (2) @(posedge i_clk);
            chk("base_clk", 32'(o_base_clk[0]), s < 2 ? 32'h0 : 32'(s - 1));
        end
        // Pin detect on channel 0, 4 clock debounce, removal on leaving inserted
        wr(adr[3], 32'hf);
        wr(adr[0], 32'h0000_0200);
        present[0] <= 1'b1;
        while (o_card_inserted[0] !== 1'b1) @(posedge i_clk);
        repeat (3) @(posedge i_clk);
        chk("irq", {31'h0, o_irq}, 32'h1);
        rd(adr[2]);
        chk("status", rdat, 32'h1);
        wr(adr[2], 32'h1);
        rd(adr[2]);
        chk("status", rdat, 32'h0);
        chk("irq", {31'h0, o_irq}, 32'h0);
        wr(adr[3], 32'h0);
        present[0] <= 1'b0;
        while (o_card_inserted[0] !== 1'b0) @(posedge i_clk);
        rd(adr[2]);
        chk("status", rdat, 32'h2);
        chk("irq", {31'h0, o_irq}, 32'h0);
        wr(adr[3], 32'h2);
        repeat (3) @(posedge i_clk);
        chk("irq", {31'h0, o_irq}, 32'h1);
        wr(adr[2], 32'hf);
        // Inverted data line 3 as detect source on channel 1
        wr(adr[1], 32'h2000_2200);
        levels[1] <= 8'h34;
        while (o_card_inserted[1] !== 1'b1) @(posedge i_clk);
        rd(adr[1]);
        chk("ctl1", rdat, 32'h2034_2200);
        rd(adr[2]);
        chk("status", rdat, 32'h4);
        // Removal reported only once debounce ends in no card
        wr(adr[2], 32'h4);
        wr(adr[1], 32'h3000_2200);
        levels[1] <= 8'h3c;
        while (o_card_inserted[1] !== 1'b0) @(posedge i_clk);
        rd(adr[2]);
        chk("status", rdat, 32'h0);
        repeat (400) @(posedge i_clk);
        rd(adr[2]);
        chk("status", rdat, 32'h8);
        complete_run();
    end
    // Whole run needs well under ten thousand cycles
    initial begin
        repeat (40000) @(posedge i_clk);
        error_cnt++;
        complete_run();
    end
endmodule
bind shcc_top shcc_top_asserts u_asserts (.*);
`default_nettype wire
